// ===== tb/cpu_bus_model.sv
`default_nettype none
module cpu_bus_model (
  input wire logic clock,
  input wire logic [7:0] bus,
  output logic cs_n,
  output logic addr,
  output logic rd_n,
  output logic wr_n,
  output logic drv_en,
  output logic [7:0] drv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus master idles deselected with both strobes high.
  initial begin
    {cs_n, addr, rd_n, wr_n, drv_en} = 5'h1E;
    drv_data = 8'h00;
  end
  // One strobed access; setup and hold span several cycles each side.
  task automatic access(input logic sel, wr, a,
      input logic [7:0] wd, output logic [7:0] rd);
    @(negedge clock);
    cs_n = !sel;
    addr = a;
    drv_en = wr;
    drv_data = wd;
    repeat (3) @(negedge clock);
    if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (6) @(negedge clock);
    rd = bus;
    {rd_n, wr_n} = 2'h3;
    repeat (2) @(negedge clock);
    {cs_n, drv_en} = 2'h2;
    repeat (6) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ===== tb/cpu_fifo_port_bench.sv
`default_nettype none
module cpu_fifo_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 32;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic mode_enable = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'hA5;
  logic tx_ready = 1'b0;
  logic usb_suspended = 1'b1;
  logic usb_configured = 1'b0;
  logic cs_n, addr, rd_n, wr_n, drv_en, oe, tx_valid, rx_ready, flush_req;
  logic [7:0] drv_data, dout, tx_data, bus, rd;
  logic [7:0] txq[$];
  int miscompares = 0;
  int n_checks = 0;
  int pops = 0;
  int flushes = 0;
  int cycles = 0;
  int n;
  always #2.5 clock = ~clock;
  // Pins are pulled up whenever nobody drives the bus.
  assign bus = oe ? dout : drv_en ? drv_data : 8'hFF;
  cpu_fifo_port #(.DEPTH(DEPTH)) cpu_fifo_port_inst (
    .clock(clock), .rst_n(rst_n), .mode_enable(mode_enable),
    .cs_n(cs_n), .port_addr_bit(addr), .rd_n(rd_n), .wr_n(wr_n),
    .port_data_in(bus), .port_data_out(dout), .port_data_oe(oe),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .flush_req(flush_req), .usb_suspended(usb_suspended),
    .usb_configured(usb_configured));
  cpu_bus_model cpu_bus_model_inst (
    .clock(clock), .bus(bus), .cs_n(cs_n), .addr(addr), .rd_n(rd_n),
    .wr_n(wr_n), .drv_en(drv_en), .drv_data(drv_data));
  // Counts pops and flushes and collects transmitted bytes.
  always @(posedge clock) begin
    if (rx_ready === 1'b1 && rx_valid) pops <= pops + 1;
    if (flush_req === 1'b1) flushes <= flushes + 1;
    if (tx_valid === 1'b1 && tx_ready) txq.push_back(tx_data);
  end
  // The receive pipe head advances after each pop; a hang is cut off.
  always @(negedge clock) begin
    rx_data <= 8'hA5 + 8'(pops);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out;
    end
  end
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // An access leaves the bus undriven once it is over.
  task automatic acc(input logic sel, wr, a, input logic [7:0] wd);
    cpu_bus_model_inst.access(sel, wr, a, wd, rd);
    chk({7'h00, oe}, 8'h00);
  endtask
  task automatic rdc(input logic sel, a, input logic [7:0] exp);
    acc(sel, 1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task automatic close_out;
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Status, receive pops, ignored accesses, fill, drain and flush.
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    mode_enable = 1'b1;
    repeat (8) @(negedge clock);
    rdc(1'b1, 1'b1, 8'h06);
    usb_suspended = 1'b0;
    usb_configured = 1'b1;
    rx_valid = 1'b1;
    rdc(1'b1, 1'b1, 8'h0B);
    rdc(1'b1, 1'b0, 8'hA5);
    rdc(1'b1, 1'b0, 8'hA6);
    chk(8'(pops), 8'h02);
    rx_valid = 1'b0;
    rdc(1'b1, 1'b1, 8'h0A);
    acc(1'b0, 1'b1, 1'b0, 8'h11);
    acc(1'b0, 1'b1, 1'b1, 8'h00);
    rdc(1'b0, 1'b1, 8'hFF);
    mode_enable = 1'b0;
    acc(1'b1, 1'b1, 1'b0, 8'h22);
    acc(1'b1, 1'b1, 1'b1, 8'h00);
    rdc(1'b1, 1'b1, 8'hFF);
    mode_enable = 1'b1;
    // An ignored write that slipped through would show on tx_valid by now.
    chk(8'(flushes + txq.size() + tx_valid), 8'h00);
    n = 0;
    do begin
      acc(1'b1, 1'b0, 1'b1, 8'h00);
      if (rd[1] !== 1'b1) break;
      acc(1'b1, 1'b1, 1'b0, 8'(n));
      n++;
    end while (n < 40);
    // The USB side holding register keeps one byte besides the FIFO.
    chk(8'(n), 8'(DEPTH + 1));
    acc(1'b1, 1'b1, 1'b0, 8'hEE);
    tx_ready = 1'b1;
    repeat (60) @(negedge clock);
    chk(8'(txq.size()), 8'(DEPTH + 1));
    foreach (txq[i]) chk(txq[i], 8'(i));
    acc(1'b1, 1'b1, 1'b1, 8'h00);
    chk(8'(flushes), 8'h01);
    close_out;
  end
endmodule
`default_nettype wire

// ===== verilog/cpu_fifo_port.sv
// Overview of operation
// - Port works only when the configuration input selects this mode.
// - Chip select high makes the port ignore address and both strobes.
// - Read strobe with address one drives the status byte on the bus.
// - Data bus is two-way: driven on reads, sampled on writes.
// - Status bit 0 is one while receive data waits.
// - Status bit 1 is one while the transmit pipe has room.
// - Status bit 2 shows suspend, status bit 3 shows configured.
// - Status bits 4 to 7 carry no meaning; the CPU ignores them.
// - Read strobe with address zero returns the next receive byte.
// - Write strobe with address zero pushes the bus byte for transmit.
// - Write strobe with address one requests a flush of pending transmit data.
// - The flush request is a one-cycle registered pulse in the port clock domain.
// - Each channel carries its own independent instance of this port.
`include "cpu_fifo_port_cfg.svh"
`default_nettype none
module cpu_fifo_port #(
  parameter int DEPTH = `TX_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mode_enable,
  input wire logic cs_n,
  input wire logic port_addr_bit,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] port_data_in,
  output logic [7:0] port_data_out,
  output logic port_data_oe,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic flush_req,
  input wire logic usb_suspended,
  input wire logic usb_configured
);
  // One instance serves one channel; nothing is shared between them.
  cpu_fifo_port_pkg::port_ctl_t raw_in, sync1_q, sync2_q, prev_q;
  cpu_fifo_port_pkg::status_t status;
  logic [7:0] din1_q, din2_q, wdata_q, wdata_d;
  logic [1:0] rst_sync_q;
  logic rst_i_n;
  logic mode1_q, mode2_q;
  logic rd_rise, wr_rise, rd_fall, active;
  logic [7:0] dout_q, dout_d;
  logic oe_q, oe_d;
  logic rx_ready_q, rx_ready_d;
  logic flush_q, flush_d;
  logic push_valid, push_ready;
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;
  logic [7:0] txd_q, txd_d;
  logic txv_q, txv_d;
  logic fifo_pop;

  // Reset release through two flip-flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_i_n = rst_sync_q[1];

  // Pin inputs pass two flip-flops before any logic sees them.
  assign raw_in = '{cs_n: cs_n, addr: port_addr_bit, rd_n: rd_n,
                    wr_n: wr_n};
  always_ff @(posedge clock or negedge rst_i_n) begin
    if (!rst_i_n) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      prev_q <= 4'hF;
      din1_q <= 8'h00;
      din2_q <= 8'h00;
      mode1_q <= 1'b0;
      mode2_q <= 1'b0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      din1_q <= port_data_in;
      din2_q <= din1_q;
      mode1_q <= mode_enable;
      mode2_q <= mode1_q;
    end
  end

  // Strobe edges count only while the mode is on and chip select is low.
  always_comb begin
    active = mode2_q && !sync2_q.cs_n;
    rd_fall = active && prev_q.rd_n && !sync2_q.rd_n;
    rd_rise = active && !prev_q.rd_n && sync2_q.rd_n;
    wr_rise = active && !prev_q.wr_n && sync2_q.wr_n;
  end

  // Status byte assembled from live block state.
  always_comb begin
    status.rx_avail = rx_valid;
    status.tx_space = push_ready;
    status.suspended = usb_suspended;
    status.configured = usb_configured;
    status.unused = `STAT_UNUSED_VAL;
  end

  // Read path: capture data on the falling strobe, pop on the rising one.
  always_comb begin
    dout_d = dout_q;
    oe_d = active && !sync2_q.rd_n && sync2_q.wr_n;
    rx_ready_d = 1'b0;
    if (rd_fall) begin
      if (sync2_q.addr == `ADDR_STATUS) begin
        dout_d = status;
      end else begin
        dout_d = rx_data;
      end
    end
    if (rd_rise && sync2_q.addr == `ADDR_DATA_PIPE && rx_valid) begin
      rx_ready_d = 1'b1;
    end
  end

  // Write path: latch bus byte while the strobe is low; act on release.
  always_comb begin
    wdata_d = (active && !sync2_q.wr_n) ? din2_q : wdata_q;
    push_valid = wr_rise && sync2_q.addr == `ADDR_DATA_PIPE;
    flush_d = wr_rise && sync2_q.addr == `ADDR_STATUS;
  end

  always_ff @(posedge clock or negedge rst_i_n) begin
    if (!rst_i_n) begin
      dout_q <= `RDATA_RESET;
      oe_q <= 1'b0;
      rx_ready_q <= 1'b0;
      wdata_q <= 8'h00;
      flush_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_q <= oe_d;
      rx_ready_q <= rx_ready_d;
      wdata_q <= wdata_d;
      flush_q <= flush_d;
    end
  end

  // Transmit pipe; a write while full is dropped as the CPU was told.
  tx_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .clock(clock),
    .rst_n(rst_i_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(wdata_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Output stage registers the FIFO head for the USB side.
  always_comb begin
    fifo_pop = fifo_out_valid && (!txv_q || tx_ready);
    txv_d = txv_q;
    txd_d = txd_q;
    if (fifo_pop) begin
      txv_d = 1'b1;
      txd_d = fifo_out_data;
    end else if (tx_ready) begin
      txv_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_i_n) begin
    if (!rst_i_n) begin
      txv_q <= 1'b0;
      txd_q <= 8'h00;
    end else begin
      txv_q <= txv_d;
      txd_q <= txd_d;
    end
  end

  assign port_data_out = dout_q;
  assign port_data_oe = oe_q;
  assign rx_ready = rx_ready_q;
  assign tx_valid = txv_q;
  assign tx_data = txd_q;
  assign flush_req = flush_q;

  // Checks on the port behaviour, all in the single clock domain.

  // The bus stays released outside a selected read.
  a_no_drive_idle: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    (sync2_q.cs_n || sync2_q.rd_n) |=> !oe_q)
    else $error("bus driven without chip select and read");

  // A selected read turns the bus around to the device.
  a_drive_on_read: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    (mode2_q && !sync2_q.cs_n && !sync2_q.rd_n && sync2_q.wr_n) |=> oe_q)
    else $error("bus not driven during read");

  // The device never drives the bus while a write is in progress.
  a_oe_read_only: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    oe_q |-> $past(sync2_q.wr_n))
    else $error("bus driven during write");

  // A status read captures the whole status byte at once.
  a_status_read: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    (rd_fall && sync2_q.addr) |=> dout_q == $past(status))
    else $error("status byte wrong");

  // Data and space bits sit at their fixed field positions.
  a_status_flow: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    (rd_fall && sync2_q.addr) |=>
    dout_q[`STAT_RX_AVAIL] == $past(rx_valid) &&
    dout_q[`STAT_TX_SPACE] == $past(push_ready))
    else $error("data or space bit wrong");

  // Suspend and configured bits follow the USB state.
  a_status_link: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    (rd_fall && sync2_q.addr) |=>
    dout_q[`STAT_SUSPEND] == $past(usb_suspended) &&
    dout_q[`STAT_CONFIGURED] == $past(usb_configured))
    else $error("suspend or configured bit wrong");

  // A data pipe read captures the receive pipe head.
  a_rd_pipe_data: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    (rd_fall && !sync2_q.addr) |=> dout_q == $past(rx_data))
    else $error("receive byte wrong");

  // A pop pulse lasts exactly one cycle.
  a_pop_once: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    rx_ready_q |=> !rx_ready_q)
    else $error("double pop");

  // A pop follows the release of a data pipe read strobe.
  a_pop_cause: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    rx_ready_q |-> $past(rd_rise) && !$past(sync2_q.addr))
    else $error("pop without read strobe");

  // A pop is only issued while the receive pipe holds data.
  a_pop_valid: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    rx_ready_q |-> $past(rx_valid))
    else $error("pop from empty receive pipe");

  // A push follows the release of a data pipe write strobe.
  a_push_cause: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    push_valid |-> !$past(sync2_q.wr_n) && !sync2_q.addr)
    else $error("push without write strobe");

  // The pushed byte is the last bus value seen under the strobe.
  a_push_data: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    (push_valid && $past(active)) |-> wdata_q == $past(din2_q))
    else $error("pushed byte wrong");

  // A push request lasts exactly one cycle.
  a_push_once: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    push_valid |=> !push_valid)
    else $error("double push");

  // A flush follows the release of a status address write strobe.
  a_flush_cause: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    flush_q |-> $past(wr_rise) && $past(sync2_q.addr))
    else $error("flush without write strobe");

  // A flush pulse lasts exactly one cycle.
  a_flush_once: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    flush_q |=> !flush_q)
    else $error("double flush");

  // Nothing happens while the port is deselected.
  a_cs_ignored: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    sync2_q.cs_n |=> !flush_q && !rx_ready_q)
    else $error("action while deselected");

  // Nothing happens while the mode is off.
  a_mode_off: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    !mode2_q |=> !oe_q && !flush_q)
    else $error("port active while mode off");

  // A byte offered to the USB side holds until it is taken.
  a_tx_hold: assert property (
    @(posedge clock) disable iff (!rst_i_n)
    (txv_q && !tx_ready) |=> txv_q && $stable(txd_q))
    else $error("transmit byte dropped or changed");

  // Main scenarios that the bench is expected to reach.
  c_status_read: cover property (@(posedge clock) rd_fall && sync2_q.addr);
  c_data_pop: cover property (@(posedge clock) rx_ready_q);
  c_push: cover property (@(posedge clock) push_valid && push_ready);
  c_flush: cover property (@(posedge clock) flush_q);
  c_tx_out: cover property (@(posedge clock) txv_q && tx_ready);
endmodule
`default_nettype wire

// ===== verilog/cpu_fifo_port_cfg.svh
`ifndef CPU_FIFO_PORT_CFG_SVH
`define CPU_FIFO_PORT_CFG_SVH
// Address bit values on the port.
`define ADDR_DATA_PIPE 1'h0
`define ADDR_STATUS 1'h1
// Status byte field positions.
`define STAT_RX_AVAIL 0
`define STAT_TX_SPACE 1
`define STAT_SUSPEND 2
`define STAT_CONFIGURED 3
// Value shown in the unused status bits.
`define STAT_UNUSED_VAL 4'h0
// Reset value of the read data holding register.
`define RDATA_RESET 8'h00
// Transmit FIFO depth.
`define TX_FIFO_DEPTH 32
`endif

// ===== verilog/cpu_fifo_port_pkg.sv
`default_nettype none
package cpu_fifo_port_pkg;
  // Strobe state of the port after synchronisation.
  typedef struct packed {
    logic cs_n;
    logic addr;
    logic rd_n;
    logic wr_n;
  } port_ctl_t;
  // Status byte layout.
  typedef struct packed {
    logic [3:0] unused;
    logic configured;
    logic suspended;
    logic tx_space;
    logic rx_avail;
  } status_t;
endpackage
`default_nettype wire

// ===== verilog/tx_fifo.sv
`include "cpu_fifo_port_cfg.svh"
`default_nettype none
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `TX_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Handshakes and pointer updates.
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage written at the write pointer.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Honest full and empty flags.
  always_comb begin
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data = mem_q[rp_q];
  end
endmodule
`default_nettype wire
